// ===== core/ucf_port.sv
// one channel of the usb bridge: fifo pin port and serial modem pins
//
// Operation
// RULE1: receive-available flag high while receive buffer empty, low when a byte waits.
// RULE2: transmit-space flag high when transmit buffer full, low when a write fits.
// RULE3: drive current receive byte on the bus only while read strobe is low.
// RULE4: rising read strobe consumes presented byte and advances to the next one.
// RULE5: falling write strobe captures the bus byte into the transmit buffer.
// RULE6: far side reads only when data flagged and writes only when space flagged.
// RULE7: suspended with wakeup enabled, low send-now pulse requests usb resume.
// RULE8: not suspended, low send-now pulse flushes buffered transmit data next bulk-in.
// RULE9: serial mode with wakeup enabled, low ring indicator requests resume.
// RULE10: serial mode drives txd, rts, dtr and samples rxd, cts, dsr, dcd, ri.
// RULE11: far side holds read strobe low at least 50 ns.
// RULE12: far side keeps read strobe high at least 50 ns plus flag hold.
// RULE13: after each read keep receive-available flag high at least 80 ns.
// RULE14: during reset the fifo status flags are not driven.
// RULE15: strobes are synchronised so each edge acts exactly once.
`timescale 1ns/1ps
module ucf_port
   import ucf_pkg::*;
#(
   parameter int DEPTH     = FIFO_DEPTH,
   parameter int HOLD_CYC  = RX_FLAG_HOLD_CYC
) (
   // clock and reset
   input  wire logic                mclk,
   input  wire logic                sys_rst,
   // configuration
   input  wire logic                mode_fifo,
   input  wire logic                wakeup_en,
   input  wire logic                suspend_indicator_n,
   // fifo strobes from the far side
   input  wire ucf_strobe_t         strobe_in,
   // fifo data bus pins
   input  wire logic [DATA_W-1:0]   fifo_bus_in,
   output logic [DATA_W-1:0]        fifo_bus_out,
   output logic                     fifo_bus_oe,
   // fifo status flag pins
   output logic                     rx_avail_n,
   output logic                     rx_avail_oe,
   output logic                     tx_space_n,
   output logic                     tx_space_oe,
   // serial modem pins
   input  wire ucf_modem_in_t       modem_in,
   output ucf_modem_out_t           modem_out,
   output ucf_modem_in_t            modem_seen,
   // serial engine side (framing lives elsewhere)
   input  wire ucf_modem_out_t      serial_drive,
   // usb side: receive data in, transmit data out
   input  wire logic                usb_rx_valid,
   input  wire logic [DATA_W-1:0]   usb_rx_data,
   output logic                     usb_rx_ready,
   output logic                     usb_tx_valid,
   output logic [DATA_W-1:0]        usb_tx_data,
   input  wire logic                usb_tx_ready,
   output ucf_usb_req_t             usb_req
);
   initial begin
      if (HOLD_CYC < 1) $error("ucf_port flag hold must be at least one cycle");
   end

   // ---------------------------------------------------------------
   // strobe and ring indicator synchronisers
   // ---------------------------------------------------------------
   logic rd_lvl, rd_fall, rd_rise;
   logic wr_lvl, wr_fall, wr_rise;
   logic sn_lvl, sn_fall, sn_rise;
   logic ri_lvl, ri_fall, ri_rise;

   ucf_sync u_sync_rd (                          // RULE15
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .async_in (strobe_in.rd_n),
      .level_q  (rd_lvl),
      .fall_q   (rd_fall),
      .rise_q   (rd_rise)
   );

   ucf_sync u_sync_wr (                          // RULE15
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .async_in (strobe_in.wr_n),
      .level_q  (wr_lvl),
      .fall_q   (wr_fall),
      .rise_q   ()
   );

   ucf_sync u_sync_sn (                          // RULE15
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .async_in (strobe_in.send_now_wake_n),
      .level_q  (sn_lvl),
      .fall_q   (sn_fall),
      .rise_q   ()
   );

   ucf_sync u_sync_ri (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .async_in (modem_in.ri_n),
      .level_q  (ri_lvl),
      .fall_q   (ri_fall),
      .rise_q   (ri_rise)
   );

   // ---------------------------------------------------------------
   // buffers toward and from usb
   // ---------------------------------------------------------------
   logic              rxb_valid;
   logic [DATA_W-1:0] rxb_data;
   logic              rxb_pop;
   logic              txb_ready;
   logic              txb_push;

   ucf_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_rx_buf (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .in_valid  (usb_rx_valid),
      .in_data   (usb_rx_data),
      .in_ready  (usb_rx_ready),
      .out_valid (rxb_valid),
      .out_data  (rxb_data),
      .out_ready (rxb_pop)
   );

   logic              txf_valid;
   logic [DATA_W-1:0] txf_data;

   ucf_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_tx_buf (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .in_valid  (txb_push),
      .in_data   (fifo_bus_in),
      .in_ready  (txb_ready),
      .out_valid (txf_valid),
      .out_data  (txf_data),
      .out_ready (usb_tx_ready)
   );

   assign usb_tx_valid = txf_valid;
   assign usb_tx_data  = txf_data;

   // ---------------------------------------------------------------
   // read side state machine
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      RD_IDLE,
      RD_ACTIVE,
      RD_HOLD
   } ucf_rd_state_t;

   ucf_rd_state_t     rd_state_q;
   ucf_rd_state_t     rd_state_d;
   logic [7:0]        hold_cnt_q;
   logic [7:0]        hold_cnt_d;
   logic              in_fifo;

   assign in_fifo = (mode_fifo == 1'b1);
   // the byte is taken off the buffer only at the end of the read cycle
   assign rxb_pop = in_fifo && (rd_state_q == RD_ACTIVE) && rd_rise && rxb_valid; // RULE4
   // a write with no space is dropped; the far side should not issue it
   assign txb_push = in_fifo && wr_fall && txb_ready;                           // RULE5 RULE6

   // next-state logic for read cycles and the post-read flag hold
   always_comb begin
      rd_state_d = rd_state_q;
      hold_cnt_d = hold_cnt_q;
      case (rd_state_q)
         RD_IDLE: begin
            if (in_fifo && rd_fall) rd_state_d = RD_ACTIVE;
         end
         RD_ACTIVE: begin
            if (rd_rise) begin
               rd_state_d = RD_HOLD;                                            // RULE13
               hold_cnt_d = 8'(HOLD_CYC);
            end
         end
         RD_HOLD: begin
            if (hold_cnt_q > 8'h01) hold_cnt_d = hold_cnt_q - 8'h01;
            else begin
               hold_cnt_d = 8'h00;
               rd_state_d = RD_IDLE;
            end
         end
         default: rd_state_d = RD_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rd_state_q <= RD_IDLE;
         hold_cnt_q <= 8'h00;
      end else begin
         rd_state_q <= rd_state_d;
         hold_cnt_q <= hold_cnt_d;
      end
   end

   // ---------------------------------------------------------------
   // fifo pin outputs
   // ---------------------------------------------------------------
   wire rx_flag_d = ~(rxb_valid && (rd_state_d != RD_HOLD));                    // RULE1 RULE13
   wire tx_flag_d = ~txb_ready;                                                 // RULE2
   wire bus_oe_d  = in_fifo && (rd_state_d == RD_ACTIVE) && ~rd_lvl;            // RULE3

   // flags float in reset and in serial mode where these pins carry modem lines
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rx_avail_n   <= 1'b1;
         rx_avail_oe  <= 1'b0;                                                  // RULE14
         tx_space_n   <= 1'b1;
         tx_space_oe  <= 1'b0;                                                  // RULE14
         fifo_bus_oe  <= 1'b0;
         fifo_bus_out <= RST_BYTE;
      end else begin
         rx_avail_n   <= rx_flag_d;
         rx_avail_oe  <= in_fifo;
         tx_space_n   <= tx_flag_d;
         tx_space_oe  <= in_fifo;
         fifo_bus_oe  <= bus_oe_d;                                              // RULE3
         fifo_bus_out <= rxb_data;
      end
   end

   // ---------------------------------------------------------------
   // serial mode pins and usb requests
   // ---------------------------------------------------------------
   // the indicator reads 1 while usb is suspended, despite its active-low style name
   wire suspended  = suspend_indicator_n;
   wire sn_wake    = sn_fall && suspended && wakeup_en;                         // RULE7
   wire sn_flush   = sn_fall && ~suspended;                                     // RULE8
   wire ri_wake    = ~in_fifo && wakeup_en && suspended && ~ri_lvl;             // RULE9

   // modem outputs idle high; inputs are registered for the serial engine
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         modem_out  <= '1;
         modem_seen <= '1;
         usb_req    <= '0;
      end else begin
         modem_out  <= in_fifo ? '1 : serial_drive;                             // RULE10
         modem_seen <= in_fifo ? '1 : modem_in;                                 // RULE10
         usb_req.resume_req <= sn_wake | ri_wake;
         usb_req.flush_req  <= sn_flush;
      end
   end
endmodule : ucf_port

// ===== core/ucf_pkg.sv
// package of constants and carrier types for the usb channel fifo/uart port
package ucf_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS      = 10;
   localparam int RX_FLAG_HOLD_NS    = 80;
   localparam int RX_FLAG_HOLD_CYC   = (RX_FLAG_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RD_PULSE_MIN_NS    = 50;
   localparam int RD_PRECHARGE_NS    = 50;
   // ---------------------------------------------------------------
   // sizes and reset values
   // ---------------------------------------------------------------
   localparam int DATA_W             = 8;
   localparam int FIFO_DEPTH         = 4;
   localparam int SYNC_STAGES        = 2;
   localparam logic RST_STROBE_LEVEL = 1'b1;
   localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;

   // channel modes
   typedef enum logic {
      UCF_MODE_SERIAL,
      UCF_MODE_FIFO
   } ucf_mode_t;

   // asynchronous strobes from the far side, all active low
   typedef struct packed {
      logic rd_n;
      logic wr_n;
      logic send_now_wake_n;
   } ucf_strobe_t;

   // modem inputs (active low except rx data)
   typedef struct packed {
      logic rxd;
      logic cts_n;
      logic dsr_n;
      logic dcd_n;
      logic ri_n;
   } ucf_modem_in_t;

   // modem outputs toward the pins
   typedef struct packed {
      logic txd;
      logic rts_n;
      logic dtr_n;
   } ucf_modem_out_t;

   // usb-side requests generated by this port
   typedef struct packed {
      logic resume_req;
      logic flush_req;
   } ucf_usb_req_t;
endpackage : ucf_pkg

// ===== core/ucf_sync.sv
// two-flop synchroniser with registered falling and rising edge pulses
`timescale 1ns/1ps
module ucf_sync
   import ucf_pkg::*;
#(
   parameter int STAGES = SYNC_STAGES
) (
   // clock and reset
   input  wire logic mclk,
   input  wire logic sys_rst,
   // asynchronous input
   input  wire logic async_in,
   // synchronised outputs
   output logic      level_q,
   output logic      fall_q,
   output logic      rise_q
);
   initial begin
      if (STAGES < 2) $error("ucf_sync needs at least two stages");
   end

   logic [STAGES-1:0] chain_q;
   logic              prev_q;

   // chain resets high since strobes idle high; only the last stage is looked at
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         chain_q <= {STAGES{RST_STROBE_LEVEL}};
         prev_q  <= RST_STROBE_LEVEL;
         fall_q  <= 1'b0;
         rise_q  <= 1'b0;
      end else begin
         chain_q <= {chain_q[STAGES-2:0], async_in};
         prev_q  <= chain_q[STAGES-1];
         fall_q  <= prev_q & ~chain_q[STAGES-1];
         rise_q  <= ~prev_q & chain_q[STAGES-1];
      end
   end

   assign level_q = prev_q;
endmodule : ucf_sync

// ===== core/ucf_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module ucf_fifo
   import ucf_pkg::*;
#(
   parameter int WIDTH = DATA_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   // fill side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   // drain side
   output logic                  out_valid,
   output logic [WIDTH-1:0]      out_data,
   input  wire logic             out_ready
);
   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("ucf_fifo depth must be a power of two >= 2");
   end

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wp_q;
   logic [AW-1:0]    rp_q;
   logic [AW:0]      cnt_q;
   wire              push = in_valid & in_ready;
   wire              pop  = out_valid & out_ready;

   // status straight from the occupancy count
   assign in_ready  = (cnt_q < (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rp_q];

   // pointers and count
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wp_q <= wp_q + 1'b1;
         if (pop)  rp_q <= rp_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // storage has no reset; only written slots are ever read
   always_ff @(posedge mclk) begin
      if (push) mem_q[wp_q] <= in_data;
   end
endmodule : ucf_fifo

// ===== testbench/ucf_port_assertions.sv
// assertion checker for the channel fifo port pins
`timescale 1ns/1ps
module ucf_port_chk
   import ucf_pkg::*;
(
   // clock and reset
   input wire logic           mclk,
   input wire logic           sys_rst,
   // inputs seen at the port
   input wire logic           mode_fifo,
   input wire logic           wakeup_en,
   input wire logic           suspend_indicator_n,
   input wire ucf_strobe_t    strobe_in,
   input wire ucf_modem_in_t  modem_in,
   input wire ucf_modem_out_t serial_drive,
   // outputs driven by the port
   input wire logic           fifo_bus_oe,
   input wire logic           rx_avail_n,
   input wire logic           rx_avail_oe,
   input wire logic           tx_space_n,
   input wire logic           tx_space_oe,
   input wire ucf_modem_out_t modem_out,
   input wire logic           usb_tx_valid,
   input wire ucf_usb_req_t   usb_req
);
   // ------------
   // properties
   // ------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   // reset is the cause here, so this one is not disabled by it
   a_rst_flags_off: assert property (disable iff (1'b0) sys_rst |=>
      !rx_avail_oe && !tx_space_oe && !fifo_bus_oe) else $error("pins driven in reset");
   a_bus_on_rd: assert property ($rose(fifo_bus_oe) |->
      !strobe_in.rd_n && $past(!strobe_in.rd_n, 3)) else $error("bus driven without read");
   a_rx_flag_hold: assert property ($fell(fifo_bus_oe) |=> rx_avail_n [*7])
      else $error("data flag back too soon");
   a_tx_full_data: assert property (tx_space_n && tx_space_oe |-> usb_tx_valid)
      else $error("space flag high with empty buffer");
   a_wr_push: assert property ($fell(strobe_in.wr_n) && !tx_space_n && mode_fifo
      |-> ##[2:6] usb_tx_valid) else $error("write byte not captured");
   a_flush_req: assert property ($fell(strobe_in.send_now_wake_n) && !suspend_indicator_n
      |-> ##[2:6] usb_req.flush_req) else $error("send-now gave no flush");
   a_wake_req: assert property ($fell(strobe_in.send_now_wake_n) && suspend_indicator_n
      && wakeup_en |-> ##[2:6] usb_req.resume_req) else $error("wake gave no resume");
   a_modem_out: assert property (!mode_fifo |=> modem_out == $past(serial_drive))
      else $error("modem outputs wrong");
   a_ring_wake: assert property ((!mode_fifo && wakeup_en && suspend_indicator_n
      && !modem_in.ri_n) [*5] |-> usb_req.resume_req) else $error("ring gave no resume");

   // main scenarios reached
   c_read: cover property ($fell(fifo_bus_oe));
   c_full: cover property (tx_space_n && tx_space_oe);
   c_resume: cover property (usb_req.resume_req);
endmodule : ucf_port_chk

bind ucf_port ucf_port_chk i_chk (.mclk, .sys_rst, .mode_fifo, .wakeup_en, .suspend_indicator_n,
   .strobe_in, .modem_in, .serial_drive, .fifo_bus_oe, .rx_avail_n, .rx_avail_oe, .tx_space_n,
   .tx_space_oe, .modem_out, .usb_tx_valid, .usb_req);

// ===== testbench/ucf_mcu.sv
// far-side logic model that strobes the fifo pins
`timescale 1ns/1ps
module ucf_mcu
   import ucf_pkg::*;
(
   // clock
   input  wire logic              mclk,
   // flags and bus seen at the pins
   input  wire logic              rx_avail_n,
   input  wire logic              tx_space_n,
   input  wire logic [DATA_W-1:0] bus,
   // strobes and bus drive
   output ucf_strobe_t            strobe,
   output logic                   drv_oe,
   output logic [DATA_W-1:0]      drv_d
);
   // strobes idle high, bus released
   initial begin
      strobe = '1;
      drv_oe = 1'b0;
      drv_d  = 8'h00;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc

   // bounded wait so a stuck flag cannot hang the model
   task automatic wait_low(input bit tx);
      int n;
      n = 0;
      while ((tx ? tx_space_n : rx_avail_n) !== 1'b0 && n < 40) begin
         cyc(1);
         n++;
      end
   endtask : wait_low

   task automatic rd(output logic [DATA_W-1:0] d);
      wait_low(1'b0);
      strobe.rd_n = 1'b0;
      cyc(7);
      d = bus;
      strobe.rd_n = 1'b1;
      cyc(14);
   endtask : rd

   // data held until a cycle after the strobe rises
   task automatic wr(input logic [DATA_W-1:0] d);
      wait_low(1'b1);
      drv_oe = 1'b1;
      drv_d = d;
      strobe.wr_n = 1'b0;
      cyc(6);
      strobe.wr_n = 1'b1;
      cyc(1);
      drv_oe = 1'b0;
      cyc(12);
   endtask : wr

   task automatic snw();
      strobe.send_now_wake_n = 1'b0;
      cyc(5);
      strobe.send_now_wake_n = 1'b1;
      cyc(8);
   endtask : snw
endmodule : ucf_mcu

// ===== testbench/tb.sv
// self-checking testbench for the channel fifo port
`timescale 1ns/1ps
module tb
   import ucf_pkg::*;
;
   logic              mclk, sys_rst, mode_fifo, wakeup_en, suspend_indicator_n;
   ucf_strobe_t       strobe_in;
   wire logic [7:0]   fifo_bus_in;
   logic [7:0]        fifo_bus_out, usb_rx_data, usb_tx_data, mcu_d;
   logic              fifo_bus_oe, rx_avail_n, rx_avail_oe, tx_space_n, tx_space_oe, mcu_oe;
   logic              usb_rx_valid, usb_rx_ready, usb_tx_valid, usb_tx_ready;
   ucf_modem_in_t     modem_in, modem_seen;
   ucf_modem_out_t    modem_out, serial_drive;
   ucf_usb_req_t      usb_req;
   int                mismatches, n_compared, n_flush, n_res;

   // released bus floats high through the pin pull-ups
   assign fifo_bus_in = fifo_bus_oe ? fifo_bus_out : (mcu_oe ? mcu_d : 8'hFF);

   ucf_port i_dut (.mclk, .sys_rst, .mode_fifo, .wakeup_en, .suspend_indicator_n, .strobe_in,
      .fifo_bus_in, .fifo_bus_out, .fifo_bus_oe, .rx_avail_n, .rx_avail_oe, .tx_space_n,
      .tx_space_oe, .modem_in, .modem_out, .modem_seen, .serial_drive, .usb_rx_valid,
      .usb_rx_data, .usb_rx_ready, .usb_tx_valid, .usb_tx_data, .usb_tx_ready, .usb_req);
   ucf_mcu i_mcu (.mclk, .rx_avail_n, .tx_space_n, .bus(fifo_bus_in), .strobe(strobe_in),
      .drv_oe(mcu_oe), .drv_d(mcu_d));

   // -----------
   // helpers
   // -----------
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // request cycles counted; pulses are too short to poll from a task
   always @(posedge mclk) begin
      if (usb_req.flush_req === 1'b1) n_flush++;
      if (usb_req.resume_req === 1'b1) n_res++;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // valid stays up; the caller lowers it after the last byte
   task automatic usb_push(input logic [7:0] d);
      int n;
      n = 0;
      usb_rx_valid = 1'b1;
      usb_rx_data = d;
      // ready is judged off the edge, then the edge that takes the byte passes
      while (usb_rx_ready !== 1'b1 && n < 20) begin
         cyc(1);
         n++;
      end
      cyc(1);
   endtask : usb_push

   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up

   // -----------
   // scenarios
   // -----------
   task automatic t_reset();
      cyc(6);
      chk({5'h00, rx_avail_oe, tx_space_oe, fifo_bus_oe}, 8'h00);
      sys_rst = 1'b0;
      cyc(3);
      chk({6'h00, rx_avail_n, tx_space_n}, 8'h02);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_read();
      logic [7:0] b [3];
      logic [7:0] d;
      b = '{8'h5A, 8'hA5, 8'h81};
      for (int i = 0; i < 3; i++) usb_push(b[i]);
      usb_rx_valid = 1'b0;
      cyc(3);
      chk({7'h00, rx_avail_n}, 8'h00);
      for (int i = 0; i < 3; i++) begin
         i_mcu.rd(d);
         chk(d, b[i]);
      end
      cyc(10);
      chk({6'h00, rx_avail_n, fifo_bus_oe}, 8'h02);
      $display("t_read done");
   endtask : t_read

   task automatic t_write();
      for (int i = 0; i < FIFO_DEPTH; i++) i_mcu.wr(8'hA0 | i[7:0]);
      chk({7'h00, tx_space_n}, 8'h01);
      usb_tx_ready = 1'b1;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         chk({7'h00, usb_tx_valid}, 8'h01);
         chk(usb_tx_data, 8'hA0 | i[7:0]);
         cyc(1);
      end
      usb_tx_ready = 1'b0;
      cyc(2);
      chk({6'h00, tx_space_n, usb_tx_valid}, 8'h00);
      $display("t_write done");
   endtask : t_write

   task automatic t_send();
      n_flush = 0;
      n_res = 0;
      i_mcu.snw();
      chk({n_flush[3:0], n_res[3:0]}, 8'h10);
      suspend_indicator_n = 1'b1;
      wakeup_en = 1'b1;
      i_mcu.snw();
      chk({n_flush[3:0], n_res[3:0]}, 8'h11);
      suspend_indicator_n = 1'b0;
      $display("t_send done");
   endtask : t_send

   task automatic t_serial();
      mode_fifo = 1'b0;
      serial_drive = 3'h2;
      modem_in = 5'h0D;
      cyc(4);
      chk({5'h00, modem_out}, 8'h02);
      chk({3'h0, modem_seen}, 8'h0D);
      suspend_indicator_n = 1'b1;
      modem_in.ri_n = 1'b0;
      cyc(6);
      chk({7'h00, usb_req.resume_req}, 8'h01);
      modem_in.ri_n = 1'b1;
      cyc(6);
      chk({7'h00, usb_req.resume_req}, 8'h00);
      wakeup_en = 1'b0;
      modem_in.ri_n = 1'b0;
      cyc(6);
      chk({7'h00, usb_req.resume_req}, 8'h00);
      $display("t_serial done");
   endtask : t_serial

   // -----------
   // main sequence
   // -----------
   initial begin
      mismatches = 0;
      n_compared = 0;
      sys_rst = 1'b1;
      mode_fifo = 1'b1;
      wakeup_en = 1'b0;
      suspend_indicator_n = 1'b0;
      modem_in = '1;
      serial_drive = '1;
      usb_rx_valid = 1'b0;
      usb_rx_data = 8'h00;
      usb_tx_ready = 1'b0;
      t_reset();
      t_read();
      t_write();
      t_send();
      t_serial();
      wrap_up();
   end

   // whole run needs well under 1000 cycles
   initial begin
      #50000;
      mismatches++;
      wrap_up();
   end
endmodule : tb
